//--- src/sci_cfg.svh
// Offsets, field positions, reset values and counts for the control-input block
`ifndef SCI_CFG_SVH
`define SCI_CFG_SVH

// Register offsets
`define SCI_REG_CTRL     8'h00
`define SCI_REG_STATUS   8'h04
`define SCI_REG_BANKS    8'h08

// Control register fields
`define SCI_CTRL_PAR_EN  0
`define SCI_CTRL_DM_EN   1
`define SCI_CTRL_DBI_EN  2
`define SCI_CTRL_TDQS_EN 3
`define SCI_CTRL_RTT_EN  4
`define SCI_CTRL_WID_LSB 5
`define SCI_CTRL_RESET   32'h0000_0050

// Width codes held in the control register
`define SCI_WID_X4       2'h0
`define SCI_WID_X8       2'h1
`define SCI_WID_X16      2'h2

// Status register fields
`define SCI_ST_PS_LSB    0
`define SCI_ST_TEST      2
`define SCI_ST_SRWAKE    3
`define SCI_ST_ERR_LSB   8

// Counts in beats and core clock cycles
`define SCI_BURST_BEATS  4'h8
`define SCI_ALERT_CYCLES 4'h6

`endif

//--- src/sci_pkg.sv
// Types shared by the control-input block
package sci_pkg;

  // Power state of the device
  typedef enum logic [1:0] {
    SCI_PS_ACTIVE,
    SCI_PS_PRE_PD,
    SCI_PS_ACT_PD,
    SCI_PS_SELF_REF
  } sci_pstate_t;

  // Decoded command
  typedef enum logic [3:0] {
    SCI_CMD_NONE,
    SCI_CMD_ACT,
    SCI_CMD_PRE,
    SCI_CMD_RD,
    SCI_CMD_WR,
    SCI_CMD_REF,
    SCI_CMD_SRE,
    SCI_CMD_MRS,
    SCI_CMD_ZQ,
    SCI_CMD_NOP,
    SCI_CMD_RFU
  } sci_cmd_t;

  // Command/address pins; addr[16:14] double as the three command pins
  typedef struct packed {
    logic        cs_n;
    logic        act_n;
    logic [17:0] addr;
    logic [1:0]  ba;
    logic [1:0]  bg;
    logic        par;
  } sci_ca_t;

  // One captured write beat with its lane enables
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  be;
  } sci_beat_t;

endpackage : sci_pkg

//--- src/sci_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
module sci_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Pins and their synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // One pair of flops per bit; the first flop feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_r;
    logic hold_r;
    always_ff @(posedge mclk) begin
      if (reset) begin
        meta_r <= 1'b0;
        hold_r <= 1'b0;
      end else begin
        meta_r <= d[i];
        hold_r <= meta_r;
      end
    end
    assign q[i] = hold_r;
  end

endmodule : sci_sync

//--- src/sci_parity.sv
// Command/address parity checker
module sci_parity
  import sci_pkg::*;
#(
  parameter logic [17:0] ADDR_USED_MASK = 18'h3_ffff
) (
  // Sampled pins and result
  input  wire sci_ca_t ca,
  output logic         par_bad
);

  // Even parity over covered pins and the parity pin; unused address pins count as zero
  // Chip select, clock enable and termination pins are left out
  assign par_bad = ^{ca.act_n, ca.addr & ADDR_USED_MASK, ca.ba, ca.bg, ca.par};

endmodule : sci_parity

//--- src/sci_top.sv
// Control-input logic of the memory device: select, decode, power states, mask, termination
`include "sci_cfg.svh"

module sci_top
  import sci_pkg::*;
#(
  parameter logic [17:0] ADDR_USED_MASK = 18'h3_ffff,
  parameter logic [3:0]  BURST_BEATS    = `SCI_BURST_BEATS,
  parameter logic [3:0]  ALERT_CYCLES   = `SCI_ALERT_CYCLES
) (
  // System
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        dev_reset_n,
  // Command and control pins
  input  wire logic        ck_t,
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic        ten,
  input  wire sci_ca_t     ca,
  // Write data pins
  input  wire logic        dqs_t,
  input  wire logic [1:0]  dm_n,
  input  wire logic [15:0] dq,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Device enables and alert
  output logic             clk_en,
  output logic             ibuf_cmd_en,
  output logic             ibuf_odt_en,
  output logic             drv_en,
  output logic             test_mode,
  output logic             rtt_dq_on,
  output logic             rtt_dm_on,
  output logic             alert_n,
  // Accepted commands and write beats
  output logic             cmd_valid,
  output sci_cmd_t         cmd,
  output sci_ca_t          cmd_ca,
  output logic             beat_valid,
  output sci_beat_t        beat
);

  logic [1:0]  prst_r;
  logic        rst;
  logic [47:0] sync_q;
  logic        ck_s, cke_s, odt_s, ten_s, dqs_s;
  sci_ca_t     ca_s;
  logic [1:0]  dm_s;
  logic [15:0] dq_s;
  logic        ck_d_r, dqs_d_r;
  logic        ck_rise, dqs_edge;
  logic [31:0] ctrl_r;
  logic [1:0]  wid;
  logic        par_bad, par_err;
  sci_cmd_t    cmd_dec;
  logic        accept;
  logic [3:0]  bank_id;
  logic [15:0] bank_open_r;
  sci_pstate_t pstate_r;
  logic        sr_wake_r;
  logic        odt_lat_r;
  logic [3:0]  beats_r;
  logic [3:0]  alert_cnt_r;
  logic [7:0]  err_cnt_r;
  logic [15:0] lane_data;
  logic [1:0]  lane_be;
  logic [31:0] status;
  logic [31:0] reg_rdata_r;
  logic        clk_en_r, ibuf_cmd_en_r, ibuf_odt_en_r, drv_en_r, test_mode_r;
  logic        rtt_dq_on_r, rtt_dm_on_r, alert_n_r, cmd_valid_r, beat_valid_r;
  sci_cmd_t    cmd_r;
  sci_ca_t     cmd_ca_r;
  sci_beat_t   beat_r;

  // Reset pin asserts at once, releases through two flops
  always_ff @(posedge mclk or negedge dev_reset_n) begin
    if (!dev_reset_n) begin
      prst_r <= 2'h3;
    end else begin
      prst_r <= {prst_r[0], 1'b0};
    end
  end
  assign rst = reset | prst_r[1];

  // All pins cross into the core clock through two flops
  sci_sync #(.W(48)) u_sync (
    .mclk  (mclk),
    .reset (rst),
    .d     ({ck_t, cke, odt, ten, dqs_t, ca, dm_n, dq}),
    .q     (sync_q)
  );
  assign {ck_s, cke_s, odt_s, ten_s, dqs_s, ca_s, dm_s, dq_s} = sync_q;

  // Edge finders for the link clock and the data strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      ck_d_r  <= 1'b0;
      dqs_d_r <= 1'b0;
    end else begin
      ck_d_r  <= ck_s;
      dqs_d_r <= dqs_s;
    end
  end
  assign ck_rise  = ck_s & ~ck_d_r;
  assign dqs_edge = dqs_s ^ dqs_d_r;
  assign wid      = ctrl_r[`SCI_CTRL_WID_LSB +: 2];

  // Parity check only for selected commands on a rising clock edge
  sci_parity #(.ADDR_USED_MASK(ADDR_USED_MASK)) u_par (
    .ca      (ca_s),
    .par_bad (par_bad)
  );
  assign par_err = ck_rise & ~ca_s.cs_n & ctrl_r[`SCI_CTRL_PAR_EN] & par_bad;

  // Command decode from pins sampled on one edge
  always_comb begin
    cmd_dec = SCI_CMD_NONE;
    if (!ca_s.cs_n) begin
      if (!ca_s.act_n) begin
        cmd_dec = SCI_CMD_ACT;
      end else begin
        case ({ca_s.addr[16], ca_s.addr[15], ca_s.addr[14]})
          3'h7:    cmd_dec = SCI_CMD_NOP;
          3'h2:    cmd_dec = SCI_CMD_PRE;
          3'h5:    cmd_dec = SCI_CMD_RD;
          3'h4:    cmd_dec = SCI_CMD_WR;
          3'h1:    cmd_dec = cke_s ? SCI_CMD_REF : SCI_CMD_SRE;
          3'h0:    cmd_dec = SCI_CMD_MRS;
          3'h6:    cmd_dec = SCI_CMD_ZQ;
          default: cmd_dec = SCI_CMD_RFU;
        endcase
      end
    end
  end

  // Commands count only when awake, not in test mode and with good parity
  assign accept  = ck_rise & (cmd_dec != SCI_CMD_NONE) & (pstate_r == SCI_PS_ACTIVE) & cke_s
                   & ~test_mode_r & ~par_err;
  assign bank_id = {ca_s.bg, ca_s.ba};

  // Accepted command with its pins; row bits include the command pins on activate
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_valid_r <= 1'b0;
      cmd_r       <= SCI_CMD_NONE;
      cmd_ca_r    <= '0;
    end else begin
      cmd_valid_r <= accept;
      if (accept) begin
        cmd_r    <= cmd_dec;
        cmd_ca_r <= ca_s;
      end
    end
  end

  // Open-row tracking per bank
  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_open_r <= 16'h0000;
    end else if (accept) begin
      case (cmd_dec)
        SCI_CMD_ACT: bank_open_r[bank_id] <= 1'b1;
        SCI_CMD_PRE: begin
          if (ca_s.addr[10]) begin
            bank_open_r <= 16'h0000;
          end else begin
            bank_open_r[bank_id] <= 1'b0;
          end
        end
        SCI_CMD_RD, SCI_CMD_WR: begin
          if (ca_s.addr[10]) begin
            bank_open_r[bank_id] <= 1'b0;
          end
        end
        default: bank_open_r <= bank_open_r;
      endcase
    end
  end

  // Power state: entry on clock enable low outside test mode; exit on first edge with it high, from self refresh only after the wake is caught
  always_ff @(posedge mclk) begin
    if (rst) begin
      pstate_r <= SCI_PS_ACTIVE;
    end else begin
      case (pstate_r)
        SCI_PS_ACTIVE: begin
          if (ck_rise && !cke_s && !test_mode_r) begin
            if (cmd_dec == SCI_CMD_SRE && !par_err && bank_open_r == 16'h0000) begin
              pstate_r <= SCI_PS_SELF_REF;
            end else if (bank_open_r != 16'h0000) begin
              pstate_r <= SCI_PS_ACT_PD;
            end else begin
              pstate_r <= SCI_PS_PRE_PD;
            end
          end
        end
        SCI_PS_PRE_PD, SCI_PS_ACT_PD: begin
          if (ck_rise && cke_s) begin
            pstate_r <= SCI_PS_ACTIVE;
          end
        end
        SCI_PS_SELF_REF: begin
          if (sr_wake_r && ck_rise && cke_s) begin
            pstate_r <= SCI_PS_ACTIVE;
          end
        end
        default: pstate_r <= SCI_PS_ACTIVE;
      endcase
    end
  end

  // Wake from self refresh is caught without waiting for a clock edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      sr_wake_r <= 1'b0;
    end else if (pstate_r == SCI_PS_SELF_REF) begin
      sr_wake_r <= sr_wake_r | cke_s;
    end else begin
      sr_wake_r <= 1'b0;
    end
  end

  // Clock, buffer and driver enables follow clock enable and power state
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_en_r      <= 1'b0;
      drv_en_r      <= 1'b0;
      ibuf_cmd_en_r <= 1'b1;
      ibuf_odt_en_r <= 1'b1;
      test_mode_r   <= 1'b0;
    end else begin
      clk_en_r      <= cke_s;
      drv_en_r      <= cke_s & ~ten_s;
      ibuf_cmd_en_r <= (pstate_r == SCI_PS_ACTIVE);
      ibuf_odt_en_r <= (pstate_r != SCI_PS_SELF_REF);
      test_mode_r   <= ten_s;
    end
  end

  // Termination pin latched on clock edges while its buffer is alive
  always_ff @(posedge mclk) begin
    if (rst) begin
      odt_lat_r <= 1'b0;
    end else if (pstate_r == SCI_PS_SELF_REF) begin
      odt_lat_r <= 1'b0;
    end else if (ck_rise) begin
      odt_lat_r <= odt_s;
    end
  end

  // Termination on data, strobes and mask pins, only when enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      rtt_dq_on_r <= 1'b0;
      rtt_dm_on_r <= 1'b0;
    end else begin
      rtt_dq_on_r <= odt_lat_r & ctrl_r[`SCI_CTRL_RTT_EN];
      rtt_dm_on_r <= odt_lat_r & ctrl_r[`SCI_CTRL_RTT_EN]
                     & ((wid == `SCI_WID_X16)
                        | ((wid == `SCI_WID_X8) & ctrl_r[`SCI_CTRL_TDQS_EN]));
    end
  end

  // Per lane: mask and inversion share the pin, each only when enabled
  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic present, masked, invert;
    assign present = (i == 0) | (wid == `SCI_WID_X16);
    assign masked  = ctrl_r[`SCI_CTRL_DM_EN] & (wid != `SCI_WID_X4) & ~dm_s[i];
    assign invert  = ctrl_r[`SCI_CTRL_DBI_EN] & ~ctrl_r[`SCI_CTRL_DM_EN]
                     & (wid != `SCI_WID_X4) & ~dm_s[i];
    assign lane_data[8*i +: 8] = invert ? ~dq_s[8*i +: 8] : dq_s[8*i +: 8];
    assign lane_be[i]          = present & ~masked;
  end

  // Write burst window and beat capture on both strobe edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      beats_r      <= 4'h0;
      beat_valid_r <= 1'b0;
      beat_r       <= '0;
    end else begin
      beat_valid_r <= dqs_edge & (beats_r != 4'h0);
      if (accept && cmd_dec == SCI_CMD_WR) begin
        beats_r <= BURST_BEATS;
      end else if (dqs_edge && beats_r != 4'h0) begin
        beats_r <= beats_r - 4'h1;
      end
      if (dqs_edge && beats_r != 4'h0) begin
        beat_r <= '{data: lane_data, be: lane_be};
      end
    end
  end

  // Alert held low for a fixed count after a parity error
  always_ff @(posedge mclk) begin
    if (rst) begin
      alert_cnt_r <= 4'h0;
      alert_n_r   <= 1'b1;
    end else begin
      if (par_err) begin
        alert_cnt_r <= ALERT_CYCLES;
      end else if (alert_cnt_r != 4'h0) begin
        alert_cnt_r <= alert_cnt_r - 4'h1;
      end
      alert_n_r <= ~(par_err | (alert_cnt_r > 4'h1));
    end
  end

  // Control register, and parity error count that a status write clears
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r    <= `SCI_CTRL_RESET;
      err_cnt_r <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `SCI_REG_CTRL) begin
        ctrl_r <= {25'h000_0000, reg_wdata[6:0]};
      end
      if (par_err) begin
        err_cnt_r <= (err_cnt_r == 8'hff) ? err_cnt_r : err_cnt_r + 8'h01;
      end else if (reg_wr && reg_addr == `SCI_REG_STATUS) begin
        err_cnt_r <= 8'h00;
      end
    end
  end

  // Status word
  always_comb begin
    status                           = 32'h0000_0000;
    status[`SCI_ST_PS_LSB +: 2]      = pstate_r;
    status[`SCI_ST_TEST]             = test_mode_r;
    status[`SCI_ST_SRWAKE]           = sr_wake_r;
    status[`SCI_ST_ERR_LSB +: 8]     = err_cnt_r;
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SCI_REG_CTRL:   reg_rdata_r <= ctrl_r;
        `SCI_REG_STATUS: reg_rdata_r <= status;
        `SCI_REG_BANKS:  reg_rdata_r <= {16'h0000, bank_open_r};
        default:         reg_rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

  // Outputs straight from flops
  assign reg_rdata   = reg_rdata_r;
  assign clk_en      = clk_en_r;
  assign ibuf_cmd_en = ibuf_cmd_en_r;
  assign ibuf_odt_en = ibuf_odt_en_r;
  assign drv_en      = drv_en_r;
  assign test_mode   = test_mode_r;
  assign rtt_dq_on   = rtt_dq_on_r;
  assign rtt_dm_on   = rtt_dm_on_r;
  assign alert_n     = alert_n_r;
  assign cmd_valid   = cmd_valid_r;
  assign cmd         = cmd_r;
  assign cmd_ca      = cmd_ca_r;
  assign beat_valid  = beat_valid_r;
  assign beat        = beat_r;

  // Checks on the logic above
  a_cs_masks_cmd: assert property (@(posedge mclk) disable iff (rst)
    (ck_rise && ca_s.cs_n) |=> !cmd_valid_r) else $error("command taken with select high");
  a_act_row_bits: assert property (@(posedge mclk) disable iff (rst)
    (accept && !ca_s.act_n) |=> (cmd_r == SCI_CMD_ACT) && (cmd_ca_r.addr == $past(ca_s.addr)))
    else $error("activate not decoded with row bits");
  a_cke_clk_off: assert property (@(posedge mclk) disable iff (rst)
    !cke_s ##1 !cke_s |-> !clk_en_r && !drv_en_r) else $error("clock running with enable low");
  a_pd_entry: assert property (@(posedge mclk) disable iff (rst)
    (pstate_r == SCI_PS_ACTIVE && ck_rise && !cke_s && !test_mode_r && cmd_dec != SCI_CMD_SRE
     && bank_open_r != 16'h0000) |=> pstate_r == SCI_PS_ACT_PD) else $error("no active power-down");
  a_sr_holds: assert property (@(posedge mclk) disable iff (rst)
    (pstate_r == SCI_PS_SELF_REF && !ck_rise) |=> pstate_r == SCI_PS_SELF_REF)
    else $error("self refresh left without clock edge");
  a_pd_buffers: assert property (@(posedge mclk) disable iff (rst)
    (pstate_r inside {SCI_PS_PRE_PD, SCI_PS_ACT_PD}) |=> !ibuf_cmd_en_r && ibuf_odt_en_r)
    else $error("wrong buffers in power-down");
  a_sr_buffers: assert property (@(posedge mclk) disable iff (rst)
    (pstate_r == SCI_PS_SELF_REF) [*3] |-> !ibuf_odt_en_r && !rtt_dq_on_r)
    else $error("termination alive in self refresh");
  a_mask_beat: assert property (@(posedge mclk) disable iff (rst)
    (dqs_edge && beats_r != 4'h0 && ctrl_r[`SCI_CTRL_DM_EN] && wid != `SCI_WID_X4 && !dm_s[0])
    |=> beat_valid_r && !beat_r.be[0]) else $error("masked beat stored");
  a_rtt_ignored: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_r[`SCI_CTRL_RTT_EN] |=> !rtt_dq_on_r && !rtt_dm_on_r) else $error("termination while off");
  a_alert_width: assert property (@(posedge mclk) disable iff (rst)
    par_err |=> !alert_n_r [*6]) else $error("alert pulse too short");
  a_parity_cs: assert property (@(posedge mclk) disable iff (rst)
    (ck_rise && ca_s.cs_n && !reg_wr) |=> $stable(err_cnt_r)) else $error("parity checked, select high");
  a_test_blocks: assert property (@(posedge mclk) disable iff (rst)
    (test_mode_r && ck_rise) |=> !cmd_valid_r) else $error("command taken in test mode");

endmodule : sci_top

//--- sim/sci_ctrl_model.sv
// Controller model: link clock, command pins, write strobe and data toward the device
module sci_ctrl_model
  import sci_pkg::*;
(
  // Core clock
  input  wire logic   mclk,
  // Pins toward the device
  output logic        ck_t,
  output logic        cke,
  output logic        odt,
  output logic        ten,
  output sci_ca_t     ca,
  output logic        dqs_t,
  output logic [1:0]  dm_n,
  output logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet pins, then a free-running 80 ns link clock
  initial begin
    ck_t  = 1'b0;
    cke   = 1'b1;
    odt   = 1'b0;
    ten   = 1'b0;
    ca    = 25'h1ff_ffff;
    dqs_t = 1'b0;
    dm_n  = 2'h3;
    dq    = 16'h0000;
    forever #40 ck_t = ~ck_t;
  end

  // One command held across a rising link edge; deselected after, other pins inverted
  task automatic send(input sci_ca_t v, input logic e);
    @(negedge ck_t);
    @(posedge mclk);
    ca  <= v;
    cke <= e;
    @(negedge ck_t);
    @(posedge mclk);
    ca <= ~v | 25'h100_0000;
  endtask : send

  // Level pins
  task automatic pins(input logic e, input logic o, input logic t);
    @(posedge mclk);
    cke <= e;
    odt <= o;
    ten <= t;
  endtask : pins

  // Eight beats, one per strobe edge, data and mask held three cycles around each edge
  task automatic burst(input logic [7:0][15:0] d, input logic [7:0][1:0] m);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      dq   <= d[i];
      dm_n <= m[i];
      repeat (3) @(posedge mclk);
      dqs_t <= ~dqs_t;
      repeat (3) @(posedge mclk);
    end
    dq   <= ~d[7];
    dm_n <= ~m[7];
  endtask : burst
endmodule : sci_ctrl_model

//--- sim/testbench.sv
// Self-checking bench for the control-input block
module testbench
  import sci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset, dev_reset_n, reg_wr, reg_rd, ck_t, cke, odt, ten, dqs_t;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  logic [1:0]  dm_n;
  logic [15:0] dq;
  sci_ca_t     ca, cmd_ca, v;
  logic        clk_en, ibuf_cmd_en, ibuf_odt_en, drv_en, test_mode, rtt_dq_on, rtt_dm_on;
  logic        alert_n, cmd_valid, beat_valid;
  sci_cmd_t    cmd;
  sci_beat_t   beat;
  sci_beat_t   beats[$];
  int          n_fail, checked, n_cmd, n_alert;

  sci_top #(.ADDR_USED_MASK(18'h1_ffff)) u_dut (.mclk, .reset, .dev_reset_n, .ck_t, .cke,
    .odt, .ten, .ca, .dqs_t, .dm_n, .dq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .clk_en, .ibuf_cmd_en, .ibuf_odt_en, .drv_en, .test_mode, .rtt_dq_on, .rtt_dm_on,
    .alert_n, .cmd_valid, .cmd, .cmd_ca, .beat_valid, .beat);
  sci_ctrl_model u_ctrl (.mclk, .ck_t, .cke, .odt, .ten, .ca, .dqs_t, .dm_n, .dq);

  // 125 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Count accepted commands, captured beats and alert cycles
  always @(posedge mclk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (beat_valid === 1'b1) beats.push_back(beat);
    if (alert_n === 1'b0) n_alert++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Power state from the status register after two link periods
  task automatic st(input logic [1:0] e);
    repeat (20) @(posedge mclk);
    rd(8'h04, q);
    chk(q & 32'h0000_0003, {30'h0, e});
  endtask : st

  // Command with correct parity; addr[16:14] carry the three command pins
  function automatic sci_ca_t mk(input logic a, input logic [2:0] c);
    sci_ca_t r;
    r = '{cs_n: 1'b0, act_n: a, addr: {1'b0, c, 14'h0000}, ba: 2'h1, bg: 2'h1, par: 1'b0};
    r.par = ^{r.act_n, r.addr, r.ba, r.bg};
    return r;
  endfunction : mk

  // Send a command, check whether it was taken and what it decoded to
  task automatic go(input sci_ca_t c, input logic take, input sci_cmd_t e);
    int n0;
    n0 = n_cmd;
    u_ctrl.send(c, u_ctrl.cke);
    repeat (12) @(posedge mclk);
    chk(n_cmd - n0, {31'h0, take});
    if (take) chk({28'h0, cmd}, {28'h0, e});
    if (take) chk({7'h00, cmd_ca}, {7'h00, c});
  endtask : go

  task automatic t_decode;
    logic [2:0] p[8] = '{3'b111, 3'b010, 3'b101, 3'b100, 3'b001, 3'b000, 3'b110, 3'b011};
    sci_cmd_t   e[8] = '{SCI_CMD_NOP, SCI_CMD_PRE, SCI_CMD_RD, SCI_CMD_WR, SCI_CMD_REF,
                         SCI_CMD_MRS, SCI_CMD_ZQ, SCI_CMD_RFU};
    go(mk(1'b0, 3'b100), 1'b1, SCI_CMD_ACT);
    go(mk(1'b1, 3'b010), 1'b1, SCI_CMD_PRE);
    for (int i = 0; i < 8; i++) go(mk(1'b1, p[i]), 1'b1, e[i]);
    v = mk(1'b1, 3'b101);
    v.cs_n = 1'b1;
    go(v, 1'b0, SCI_CMD_NONE);
  endtask : t_decode

  // Write burst under a given width and mask setting
  task automatic t_burst(input logic [31:0] ctl, input logic dm, input logic [1:0] ln);
    logic [7:0][15:0] d;
    logic [7:0][1:0]  m;
    logic [1:0]       be;
    logic [15:0]      x;
    logic             inv;
    // Inversion only with inversion on, mask off, and a width that has the pin
    inv = ctl[2] & ~ctl[1] & (ctl[6:5] != 2'h0);
    for (int i = 0; i < 8; i++) begin
      d[i] = {4{i[3:0]}} ^ 16'h5a3c;
      m[i] = i[1:0];
    end
    wr(8'h00, ctl);
    go(mk(1'b1, 3'b100), 1'b1, SCI_CMD_WR);
    beats.delete();
    u_ctrl.burst(d, m);
    repeat (8) @(posedge mclk);
    chk(beats.size(), 8);
    for (int i = 0; i < 8 && i < beats.size(); i++) begin
      be = ln & (dm ? m[i] : 2'h3);
      x  = d[i] ^ {{8{inv & ~m[i][1]}}, {8{inv & ~m[i][0]}}};
      chk({beats[i].be, beats[i].data & {{8{ln[1]}}, {8{ln[0]}}}},
          {be, x & {{8{ln[1]}}, {8{ln[0]}}}});
    end
  endtask : t_burst

  task automatic t_parity;
    wr(8'h00, 32'h0000_0053);
    n_alert = 0;
    v = mk(1'b1, 3'b101);
    v.par = ~v.par;
    go(v, 1'b0, SCI_CMD_NONE);
    repeat (6) @(posedge mclk);
    chk(n_alert, 6);
    v.cs_n = 1'b1;
    go(v, 1'b0, SCI_CMD_NONE);
    v = mk(1'b1, 3'b101);
    v.addr[17] = 1'b1;
    go(v, 1'b1, SCI_CMD_RD);
    chk(n_alert, 6);
    rd(8'h04, q);
    chk(q & 32'h0000_ff00, 32'h0000_0100);
    wr(8'h04, 32'h0000_0000);
    rd(8'h04, q);
    chk(q & 32'h0000_ff00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0050);
  endtask : t_parity

  task automatic t_power;
    u_ctrl.pins(1'b0, 1'b0, 1'b0);
    st(2'h1);
    chk({clk_en, ibuf_cmd_en, ibuf_odt_en}, 3'b001);
    go(mk(1'b1, 3'b101), 1'b0, SCI_CMD_NONE);
    u_ctrl.pins(1'b1, 1'b0, 1'b0);
    st(2'h0);
    chk(clk_en, 1'b1);
    go(mk(1'b0, 3'b000), 1'b1, SCI_CMD_ACT);
    u_ctrl.pins(1'b0, 1'b0, 1'b0);
    st(2'h2);
    u_ctrl.pins(1'b1, 1'b0, 1'b0);
    st(2'h0);
    go(mk(1'b1, 3'b010), 1'b1, SCI_CMD_PRE);
    u_ctrl.send(mk(1'b1, 3'b001), 1'b0);
    st(2'h3);
    chk({ibuf_cmd_en, ibuf_odt_en}, 2'b00);
    u_ctrl.pins(1'b1, 1'b0, 1'b0);
    st(2'h0);
  endtask : t_power

  task automatic t_misc;
    u_ctrl.pins(1'b1, 1'b1, 1'b0);
    repeat (20) @(posedge mclk);
    chk({rtt_dq_on, rtt_dm_on}, 2'b11);
    wr(8'h00, 32'h0000_0030);
    repeat (20) @(posedge mclk);
    chk({rtt_dq_on, rtt_dm_on}, 2'b10);
    wr(8'h00, 32'h0000_0038);
    repeat (20) @(posedge mclk);
    chk({rtt_dq_on, rtt_dm_on}, 2'b11);
    wr(8'h00, 32'h0000_0040);
    repeat (20) @(posedge mclk);
    chk({rtt_dq_on, rtt_dm_on}, 2'b00);
    u_ctrl.pins(1'b1, 1'b0, 1'b1);
    repeat (10) @(posedge mclk);
    chk({test_mode, drv_en}, 2'b10);
    u_ctrl.pins(1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge mclk);
    chk({test_mode, drv_en}, 2'b01);
    @(posedge mclk);
    dev_reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({clk_en, alert_n, cmd_valid}, 3'b010);
    dev_reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'h00, q);
    chk(q, 32'h0000_0050);
  endtask : t_misc

  task automatic results;
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // Limit on the whole run; running out counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    results();
  end

  // Reset, register defaults, then the scenarios
  initial begin
    reset       = 1'b1;
    dev_reset_n = 1'b1;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0000_0000;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(8'h00, q);
    chk(q, 32'h0000_0050);
    rd(8'h0c, q);
    chk(q, 32'h0000_0000);
    t_decode();
    t_burst(32'h0000_0052, 1'b1, 2'b11);
    t_burst(32'h0000_0030, 1'b0, 2'b01);
    t_burst(32'h0000_0012, 1'b0, 2'b01);
    t_burst(32'h0000_0054, 1'b0, 2'b11);
    t_parity();
    t_power();
    t_misc();
    results();
  end
endmodule : testbench
